// ===== src/psm_defs.svh
// register offsets, field positions, reset values and timing counts for the phase-shed mirror bank
`ifndef PSM_DEFS_SVH
`define PSM_DEFS_SVH
`define PSM_OFS_MIN_PHASE 16'h00FB
`define PSM_OFS_TEMP_ZONE 16'hFE02
`define PSM_OFS_IOUT 16'hFE03
`define PSM_OFS_SETPOINT 16'hFE04
`define PSM_OFS_PWR_STATE 16'hFE05
`define PSM_OFS_OFFSET 16'hFE06
`define PSM_OFS_ENERGY_DUR 16'hFE07
`define PSM_OFS_MAX_CUR 16'hFE08
`define PSM_OFS_MAX_TEMP 16'hFE09
`define PSM_OFS_FAST_RAMP 16'hFE0A
`define PSM_OFS_SLOW_RAMP 16'hFE0B
`define PSM_OFS_MULTI_CFG 16'hFE0C
`define PSM_OFS_VOUT_MAX 16'hFE0D
`define PSM_MIN_PS2_HI 12
`define PSM_MIN_PS2_LO 10
`define PSM_FRACT_HI 9
`define PSM_FRACT_LO 6
`define PSM_MIN_PS1_HI 5
`define PSM_MIN_PS1_LO 3
`define PSM_MIN_PS0_HI 2
`define PSM_MIN_PS0_LO 0
`define PSM_MIN_PHASE_RST 13'h0249
`define PSM_STATE_ZERO 8'h00
`define PSM_STATE_ONE 8'h01
`define PSM_STATE_TWO 8'h02
`define PSM_INTERVAL_US 1200
`define PSM_CLK_MHZ 25
`endif

// ===== src/psm_pkg.sv
// types shared by the phase-shed mirror bank
`default_nettype none
package psm_pkg;
   // one register-port request
   typedef struct packed {
      logic wr;
      logic rd;
      logic [15:0] addr;
      logic [19:0] wdata;
   } psm_req_t;
   // one register-port answer
   typedef struct packed {
      logic ack;
      logic bad_addr;
      logic [19:0] rdata;
   } psm_rsp_t;
   typedef enum logic [0:0] {
      PSM_IDLE,
      PSM_RUN
   } psm_acc_state_t;
endpackage
`default_nettype wire

// ===== src/psm_regs.sv
// phase-shed minimum-phase register, energy accumulation and processor-link mirror registers
//
// How it works
// R01: min-phase register holds three 3-bit fields for states two, one, zero.
// R02: state-zero minimum applies unless the last commanded power state is one or two.
// R03: minimum above configured phase count drops the write, sets unsupported-data flag.
// R04: any one field too large rejects the whole write, old contents kept.
// R05: temperature-zone mirror is 8-bit volatile, no nonvolatile save or restore.
// R06: output-current mirror is 8-bit volatile, reported to the link.
// R07: link mirror writes take effect only while the lock control unlocks them.
// R08: setpoint mirror holds the last 10-bit commanded setpoint code, volatile.
// R09: power-state mirror holds the last 8-bit commanded power state, volatile.
// R10: offset mirror holds the 8-bit link-commanded voltage offset.
// R11: energy command write starts summing average power per 1.2 ms interval.
// R12: accumulation stops after field value times 1.2 ms intervals.
// R13: max-current mirror only reported; no effect on overcurrent protection.
// R14: max-temperature mirror only reported; no effect on overtemperature protection.
// R15: ramp mirrors are writable, only reported; real ramps come from internal step settings.
// R16: multi-regulator config mirror is 2-bit volatile.
`include "psm_defs.svh"
`default_nettype none
module psm_regs #(
   parameter int PHASES_W = 3,
   parameter int POWER_W = 16,
   parameter int ACC_W = 48,
   parameter int INTERVAL_CYCLES = (`PSM_INTERVAL_US * `PSM_CLK_MHZ)
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // register port from the host command decoder
   input wire psm_pkg::psm_req_t req,
   output psm_pkg::psm_rsp_t rsp,
   // phase configuration and lock from outside the block
   input wire logic [PHASES_W-1:0] configured_phases,
   input wire logic link_register_lock,
   // link-side updates of the commanded values
   input wire logic link_cmd_valid,
   input wire logic [9:0] link_cmd_setpoint,
   input wire logic [7:0] link_cmd_power_state,
   input wire logic [7:0] link_cmd_offset,
   // power sample for energy accumulation
   input wire logic [POWER_W-1:0] avg_power,
   // status and steering outputs
   output logic unsupported_data,
   output logic [PHASES_W-1:0] active_min_phases,
   output logic [3:0] skip_tuning_fraction,
   output logic accumulating,
   output logic [ACC_W-1:0] energy_total,
   // mirrors reported to the processor link
   output logic [7:0] link_temperature_zone,
   output logic [7:0] link_output_current,
   output logic [9:0] last_setpoint_code,
   output logic [7:0] last_power_state,
   output logic [7:0] link_commanded_offset,
   output logic [7:0] link_max_current,
   output logic [7:0] link_max_temperature,
   output logic [7:0] link_fast_ramp_rate,
   output logic [7:0] link_slow_ramp_rate,
   output logic [1:0] link_multi_regulator_cfg,
   output logic [7:0] link_max_output_voltage
);
   import psm_pkg::*;

   // =====================================================================
   // state
   typedef struct packed {
      logic [12:0] min_phase;
      logic unsup;
      logic [7:0] temp_zone;
      logic [7:0] iout;
      logic [9:0] setpoint;
      logic [7:0] pwr_state;
      logic [7:0] offset;
      logic [19:0] duration;
      logic [7:0] max_cur;
      logic [7:0] max_temp;
      logic [7:0] fast_ramp;
      logic [7:0] slow_ramp;
      logic [1:0] multi_cfg;
      logic [7:0] vout_max;
      psm_acc_state_t acc_st;
      logic [31:0] tick_cnt;
      logic [19:0] intervals;
      logic [ACC_W-1:0] total;
      psm_rsp_t rsp;
   } psm_state_t;

   psm_state_t st_ff;
   psm_state_t nxt_st;

   // =====================================================================
   // helpers
   // a field code counts only as phases; any code above the configured phase count is too big
   function automatic logic field_too_big(input logic [2:0] code, input logic [PHASES_W-1:0] limit);
      // compare as integers so any phase-count width works without zero-width padding
      field_too_big = (int'(code) > int'(limit));
   endfunction

   logic [2:0] f_ps2;
   logic [2:0] f_ps1;
   logic [2:0] f_ps0;
   logic reject;
   logic wr_ok;
   assign f_ps2 = req.wdata[`PSM_MIN_PS2_HI:`PSM_MIN_PS2_LO];
   assign f_ps1 = req.wdata[`PSM_MIN_PS1_HI:`PSM_MIN_PS1_LO];
   assign f_ps0 = req.wdata[`PSM_MIN_PS0_HI:`PSM_MIN_PS0_LO];
   assign reject = field_too_big(f_ps2, configured_phases) | // R04
                   field_too_big(f_ps1, configured_phases) |
                   field_too_big(f_ps0, configured_phases);
   assign wr_ok = req.wr & ~link_register_lock; // R07

   // =====================================================================
   // next state
   always_comb begin
      nxt_st = st_ff;
      nxt_st.rsp = '0;
      nxt_st.rsp.ack = req.wr | req.rd;
      // link commands refresh the commanded-value mirrors
      if (link_cmd_valid) begin
         nxt_st.setpoint = link_cmd_setpoint; // R08
         nxt_st.pwr_state = link_cmd_power_state; // R09
         nxt_st.offset = link_cmd_offset; // R10
      end
      if (req.wr) begin
         case (req.addr)
            `PSM_OFS_MIN_PHASE: begin
               if (reject) begin
                  nxt_st.unsup = 1'b1; // R03
               end else begin
                  nxt_st.min_phase = req.wdata[12:0]; // R01
               end
            end
            `PSM_OFS_ENERGY_DUR: begin
               nxt_st.duration = req.wdata;
               nxt_st.acc_st = PSM_RUN; // R11
               nxt_st.tick_cnt = '0;
               nxt_st.intervals = '0;
               nxt_st.total = '0;
            end
            // mirrors are volatile: only reset, writes and link commands set them, no nonvolatile path
            `PSM_OFS_TEMP_ZONE: if (wr_ok) nxt_st.temp_zone = req.wdata[7:0]; // R05
            `PSM_OFS_IOUT: if (wr_ok) nxt_st.iout = req.wdata[7:0]; // R06
            `PSM_OFS_SETPOINT: if (wr_ok) nxt_st.setpoint = req.wdata[9:0]; // R08
            `PSM_OFS_PWR_STATE: if (wr_ok) nxt_st.pwr_state = req.wdata[7:0]; // R09
            `PSM_OFS_OFFSET: if (wr_ok) nxt_st.offset = req.wdata[7:0]; // R10
            `PSM_OFS_MAX_CUR: if (wr_ok) nxt_st.max_cur = req.wdata[7:0]; // R13
            `PSM_OFS_MAX_TEMP: if (wr_ok) nxt_st.max_temp = req.wdata[7:0]; // R14
            `PSM_OFS_FAST_RAMP: if (wr_ok) nxt_st.fast_ramp = req.wdata[7:0]; // R15
            `PSM_OFS_SLOW_RAMP: if (wr_ok) nxt_st.slow_ramp = req.wdata[7:0]; // R15
            `PSM_OFS_MULTI_CFG: if (wr_ok) nxt_st.multi_cfg = req.wdata[1:0]; // R16
            `PSM_OFS_VOUT_MAX: if (wr_ok) nxt_st.vout_max = req.wdata[7:0];
            default: nxt_st.rsp.bad_addr = 1'b1;
         endcase
      end
      if (req.rd) begin
         case (req.addr)
            `PSM_OFS_MIN_PHASE: nxt_st.rsp.rdata = {7'h00, st_ff.min_phase};
            `PSM_OFS_TEMP_ZONE: nxt_st.rsp.rdata = {12'h000, st_ff.temp_zone};
            `PSM_OFS_IOUT: nxt_st.rsp.rdata = {12'h000, st_ff.iout};
            `PSM_OFS_SETPOINT: nxt_st.rsp.rdata = {10'h000, st_ff.setpoint};
            `PSM_OFS_PWR_STATE: nxt_st.rsp.rdata = {12'h000, st_ff.pwr_state};
            `PSM_OFS_OFFSET: nxt_st.rsp.rdata = {12'h000, st_ff.offset};
            `PSM_OFS_ENERGY_DUR: nxt_st.rsp.rdata = st_ff.duration;
            `PSM_OFS_MAX_CUR: nxt_st.rsp.rdata = {12'h000, st_ff.max_cur};
            `PSM_OFS_MAX_TEMP: nxt_st.rsp.rdata = {12'h000, st_ff.max_temp};
            `PSM_OFS_FAST_RAMP: nxt_st.rsp.rdata = {12'h000, st_ff.fast_ramp};
            `PSM_OFS_SLOW_RAMP: nxt_st.rsp.rdata = {12'h000, st_ff.slow_ramp};
            `PSM_OFS_MULTI_CFG: nxt_st.rsp.rdata = {18'h00000, st_ff.multi_cfg};
            `PSM_OFS_VOUT_MAX: nxt_st.rsp.rdata = {12'h000, st_ff.vout_max};
            default: nxt_st.rsp.bad_addr = 1'b1;
         endcase
      end
      // energy accumulation: one sample of average power per interval
      case (st_ff.acc_st)
         PSM_IDLE: begin
         end
         PSM_RUN: begin
            if (!(req.wr && req.addr == `PSM_OFS_ENERGY_DUR)) begin
               if (st_ff.intervals >= st_ff.duration) begin
                  nxt_st.acc_st = PSM_IDLE; // R12
               end else if (st_ff.tick_cnt == 32'(INTERVAL_CYCLES - 1)) begin
                  nxt_st.tick_cnt = '0;
                  nxt_st.intervals = st_ff.intervals + 20'h00001;
                  nxt_st.total = st_ff.total + ACC_W'(avg_power); // R11
               end else begin
                  nxt_st.tick_cnt = st_ff.tick_cnt + 32'h00000001;
               end
            end
         end
         default: nxt_st.acc_st = PSM_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_ff <= '0;
         st_ff.min_phase <= `PSM_MIN_PHASE_RST;
         st_ff.acc_st <= PSM_IDLE;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // =====================================================================
   // outputs
   // ramp mirrors and max-current/temperature mirrors drive only the link report outputs
   always_comb begin
      case (st_ff.pwr_state)
         `PSM_STATE_ONE: active_min_phases = PHASES_W'(st_ff.min_phase[`PSM_MIN_PS1_HI:`PSM_MIN_PS1_LO]); // R02
         `PSM_STATE_TWO: active_min_phases = PHASES_W'(st_ff.min_phase[`PSM_MIN_PS2_HI:`PSM_MIN_PS2_LO]); // R02
         default: active_min_phases = PHASES_W'(st_ff.min_phase[`PSM_MIN_PS0_HI:`PSM_MIN_PS0_LO]); // R02
      endcase
   end

   assign rsp = st_ff.rsp;
   assign unsupported_data = st_ff.unsup;
   assign skip_tuning_fraction = st_ff.min_phase[`PSM_FRACT_HI:`PSM_FRACT_LO];
   assign accumulating = (st_ff.acc_st == PSM_RUN);
   assign energy_total = st_ff.total;
   assign link_temperature_zone = st_ff.temp_zone;
   assign link_output_current = st_ff.iout;
   assign last_setpoint_code = st_ff.setpoint;
   assign last_power_state = st_ff.pwr_state;
   assign link_commanded_offset = st_ff.offset;
   assign link_max_current = st_ff.max_cur; // R13
   assign link_max_temperature = st_ff.max_temp; // R14
   assign link_fast_ramp_rate = st_ff.fast_ramp; // R15
   assign link_slow_ramp_rate = st_ff.slow_ramp; // R15
   assign link_multi_regulator_cfg = st_ff.multi_cfg;
   assign link_max_output_voltage = st_ff.vout_max;
endmodule
`default_nettype wire

// ===== tb/psm_regs_monitor.sv
// port-level assertion checker for the phase-shed mirror bank
`default_nettype none
module psm_regs_monitor #(parameter int PHASES_W = 3) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // observed ports
   input wire psm_pkg::psm_req_t req,
   input wire psm_pkg::psm_rsp_t rsp,
   input wire logic [PHASES_W-1:0] configured_phases,
   input wire logic link_register_lock,
   input wire logic link_cmd_valid,
   input wire logic [7:0] link_cmd_power_state,
   input wire logic unsupported_data,
   input wire logic [3:0] skip_tuning_fraction,
   input wire logic accumulating,
   input wire logic [7:0] link_temperature_zone,
   input wire logic [7:0] last_power_state
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   wire logic wr_fb = req.wr && req.addr == 16'h00FB;
   wire logic big = req.wdata[12:10] > configured_phases || req.wdata[5:3] > configured_phases
      || req.wdata[2:0] > configured_phases;
   // =====
   // bus handshake and the checks on the bank's own outputs
   ack_follows_req_a: assert property ((req.wr || req.rd) |=> rsp.ack)
      else $error("request without acknowledge");
   quiet_rdata_a: assert property (!req.rd |=> rsp.rdata == 20'h00000)
      else $error("read data not zero outside a read");
   flag_sticky_a: assert property (unsupported_data |=> unsupported_data)
      else $error("unsupported flag dropped");
   reject_keeps_a: assert property (wr_fb && big |=> unsupported_data && $stable(skip_tuning_fraction))
      else $error("oversized phase write not rejected");
   accept_no_flag_a: assert property (wr_fb && !big && !unsupported_data |=> !unsupported_data)
      else $error("valid phase write flagged");
   lock_blocks_a: assert property (req.wr && link_register_lock && req.addr == 16'hFE02
      |=> $stable(link_temperature_zone))
      else $error("locked mirror write took effect");
   link_state_a: assert property (link_cmd_valid && !(req.wr && req.addr == 16'hFE05)
      |=> last_power_state == $past(link_cmd_power_state))
      else $error("power state mirror missed link command");
   acc_starts_a: assert property (req.wr && req.addr == 16'hFE07 |=> accumulating)
      else $error("accumulation did not start");
   cover property (wr_fb && big);
   cover property (link_cmd_valid);
   cover property ($fell(accumulating));
endmodule
bind psm_regs psm_regs_monitor #(.PHASES_W(PHASES_W)) i_psm_regs_monitor (.clk(clk), .rst(rst), .req(req),
   .rsp(rsp), .configured_phases(configured_phases), .link_register_lock(link_register_lock),
   .link_cmd_valid(link_cmd_valid), .link_cmd_power_state(link_cmd_power_state),
   .unsupported_data(unsupported_data), .skip_tuning_fraction(skip_tuning_fraction),
   .accumulating(accumulating), .link_temperature_zone(link_temperature_zone),
   .last_power_state(last_power_state));
`default_nettype wire

// ===== tb/psm_link_model.sv
// processor-link and power-sample partner for the phase-shed mirror bank
`default_nettype none
module psm_link_model (
   // clock
   input wire logic clk,
   // link commands and power sample
   output logic link_cmd_valid,
   output logic [9:0] link_cmd_setpoint,
   output logic [7:0] link_cmd_power_state,
   output logic [7:0] link_cmd_offset,
   output logic [15:0] avg_power
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      link_cmd_valid = 1'b0;
      {link_cmd_setpoint, link_cmd_power_state, link_cmd_offset} = '0;
      avg_power = 16'h0010;
   end
   // after a command the fields carry its inverse, so a stale value never looks fresh
   task automatic send(input logic [7:0] st, input logic [9:0] sp, input logic [7:0] ofs, input int slow);
      repeat (slow) @(posedge clk);
      @(posedge clk) #1;
      link_cmd_valid = 1'b1;
      {link_cmd_setpoint, link_cmd_power_state, link_cmd_offset} = {sp, st, ofs};
      @(posedge clk) #1;
      link_cmd_valid = 1'b0;
      {link_cmd_setpoint, link_cmd_power_state, link_cmd_offset} = ~{sp, st, ofs};
   endtask
endmodule
`default_nettype wire

// ===== tb/tb.sv
// self-checking testbench for the phase-shed mirror bank
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin failures++; \
   $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module tb;
   import psm_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0;
   logic rst = 1'b1;
   psm_req_t req = '0;
   psm_rsp_t rsp;
   logic [2:0] cfg = 3'h6;
   logic lock = 1'b0;
   logic cv;
   logic [9:0] csp, m_sp;
   logic [7:0] cst, cof, m_ps, m_of;
   logic [7:0] tz;
   logic bad_seen = 1'b0;
   logic [15:0] pw;
   logic unsup, acc;
   logic [2:0] amp;
   logic [3:0] frac;
   logic [47:0] etot;
   int failures = 0;
   int samples_checked = 0;
   logic [19:0] bad[3] = '{20'h012AA, 20'h01A9A, 20'h0129F};
   always #20 clk = ~clk;
   psm_link_model i_psm_link_model (.clk(clk), .link_cmd_valid(cv), .link_cmd_setpoint(csp),
      .link_cmd_power_state(cst), .link_cmd_offset(cof), .avg_power(pw));
   psm_regs #(.INTERVAL_CYCLES(4)) i_psm_regs (.clk(clk), .rst(rst), .req(req), .rsp(rsp),
      .configured_phases(cfg), .link_register_lock(lock), .link_cmd_valid(cv), .link_cmd_setpoint(csp),
      .link_cmd_power_state(cst), .link_cmd_offset(cof), .avg_power(pw), .unsupported_data(unsup),
      .active_min_phases(amp), .skip_tuning_fraction(frac), .accumulating(acc), .energy_total(etot),
      .link_temperature_zone(tz), .link_output_current(), .last_setpoint_code(m_sp), .last_power_state(m_ps),
      .link_commanded_offset(m_of), .link_max_current(), .link_max_temperature(), .link_fast_ramp_rate(),
      .link_slow_ramp_rate(), .link_multi_regulator_cfg(), .link_max_output_voltage());
   // =====
   // bus access: request held one cycle, answer looked at in the cycle it stands
   task automatic xfer(input logic w, input logic [15:0] a, input logic [19:0] d, output logic [19:0] q);
      @(posedge clk) #1;
      req = '{wr: w, rd: !w, addr: a, wdata: d};
      @(posedge clk) #1;
      `CHK(rsp.ack, 1'b1)
      q = rsp.rdata;
      bad_seen = rsp.bad_addr;
      req = '0;
   endtask
   task automatic wr(input logic [15:0] a, input logic [19:0] d);
      logic [19:0] q;
      xfer(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [15:0] a, input logic [19:0] e);
      logic [19:0] q;
      xfer(1'b0, a, 20'h00000, q);
      `CHK(q, e)
   endtask
   task automatic give_verdict();
      $display("checks %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial begin
      #100000;
      failures++;
      give_verdict();
   end
   initial begin
      repeat (6) @(posedge clk);
      #1 rst = 1'b0;
      rd(16'h00FB, 20'h00249);
      for (int i = 2; i < 14; i++)
         rd(16'hFE00 + 16'(i), 20'h00000);
      $display("reset test done");
      cfg = 3'h4;
      wr(16'h00FB, 20'h0129A);
      rd(16'h00FB, 20'h0129A);
      `CHK({amp, frac, unsup}, 8'h54)
      for (int i = 0; i < 3; i++) begin
         wr(16'h00FB, bad[i]);
         rd(16'h00FB, 20'h0129A);
      end
      `CHK(unsup, 1'b1)
      $display("phase test done");
      i_psm_link_model.send(8'h01, 10'h3A5, 8'h7E, 0);
      `CHK({m_ps, amp, m_sp, m_of}, 29'h002FA57E)
      i_psm_link_model.send(8'h02, 10'h001, 8'h00, 3);
      `CHK(amp, 3'h4)
      $display("link test done");
      for (int i = 2; i < 14; i++) begin
         if (i == 7)
            continue;
         wr(16'hFE00 + 16'(i), 20'hFFFFF);
         rd(16'hFE00 + 16'(i), i == 4 ? 20'h003FF : i == 12 ? 20'h00003 : 20'h000FF);
      end
      lock = 1'b1;
      wr(16'hFE02, 20'h00011);
      rd(16'hFE02, 20'h000FF);
      `CHK(tz, 8'hFF)
      lock = 1'b0;
      rd(16'hFE01, 20'h00000);
      `CHK(bad_seen, 1'b1)
      $display("mirror test done");
      wr(16'hFE07, 20'h00002);
      `CHK(acc, 1'b1)
      for (int n = 0; n < 40 && acc; n++)
         @(posedge clk) #1;
      `CHK({acc, etot}, 49'h20)
      $display("energy test done");
      give_verdict();
   end
endmodule
`default_nettype wire
